/* File: fpusc_core.sv */
// Status word, control word and exception logic of the numeric coprocessor
//
// Function
// RULE_01: Status bit 15 is one while executing or interrupt pending, else zero.
// RULE_02: Front-unit status and control instructions never set the busy bit.
// RULE_03: Status bits 14-12 hold the three-bit stack top pointer.
// RULE_04: Status bit 7 set when any flag is set with its mask clear.
// RULE_05: Status bits 5-0 are exception flags set on detected exceptions.
// RULE_06: Every math instruction saves instruction address, operand address and opcode; the operand address is saved only when cmd_has_mem is set.
// RULE_07: Compare and test write C3,C2,C0 by outcome; C1 kept.
// RULE_08: Remainder complete: C2 zero, C3 C1 C0 take quotient bits 1,0,2.
// RULE_09: Examine writes class code into C3..C0 with sign in C1.
// RULE_10: Remainder keeps C3,C1 below twice modulus; C3 below four times.
// RULE_11: Control bits 5-0 mask exceptions; bit 7 masks all interrupts.
// RULE_12: Control bits 9-8 select internal precision.
// RULE_13: Control bits 11-10 select the rounding mode.
// RULE_14: A control bit selects affine or projective infinity closure.
// RULE_15: Unmasked exception raises interrupt when the general mask allows.
// RULE_16: With interrupts disabled, execution continues regardless of pending flags.
// RULE_17: Masked exception still sets its flag and applies default fix-up.
// RULE_18: Invalid raised on stack overflow, underflow, indeterminate form, NaN operand.
// RULE_19: Masked invalid gives default quiet NaN or propagates a NaN operand.
// RULE_20: Host loads the control word; new settings apply from then on.
// RULE_21: Push decrements top before write; pop increments top after read.
// RULE_22: External busy output asserts when the execution unit starts.
// RULE_23: Flags stay set until cleared; interrupt bit follows flags and masks.
`timescale 1ns/1ns
module fpusc_core (
  input  wire logic                 core_clk,
  input  wire logic                 reset_n,
  input  wire logic                 cmd_valid,
  input  wire fpusc_pkg::fpusc_cmd_t cmd_op,
  input  wire logic [15:0]          cmd_data,
  input  wire logic                 cmd_has_mem,
  input  wire logic [19:0]          cmd_instr_addr,
  input  wire logic [19:0]          cmd_opnd_addr,
  input  wire logic [10:0]          cmd_opcode,
  input  wire logic                 exec_done,
  input  wire logic [5:0]           exec_exc,
  input  wire logic                 exec_nan_operand,
  input  wire fpusc_pkg::fpusc_cmp_t cmp_result,
  input  wire logic                 rem_complete,
  input  wire fpusc_pkg::fpusc_rng_t rem_range,
  input  wire logic [2:0]           rem_quot,
  input  wire fpusc_pkg::fpusc_cls_t exam_class,
  input  wire logic                 exam_sign,
  input  wire logic [1:0]           ptr_rd_sel,
  output logic [15:0]               status_word_q,
  output logic [15:0]               control_word_q,
  output logic                      busy_pin_q,
  output logic                      int_pin_q,
  output fpusc_pkg::fpusc_fix_t     nan_fixup_q,
  output logic [19:0]               ptr_rd_data_q
);
  import fpusc_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  fpusc_state_t state_q, state_d;
  fpusc_cmd_t   op_q, op_d;
  logic [2:0]   top_q, top_d;
  logic [7:0]   occ_q, occ_d;
  logic [5:0]   flags_q, flags_d;
  logic [3:0]   cc_q, cc_d;
  logic [15:0]  cw_q, cw_d;
  logic         busy_pin_d, int_pin_d;
  fpusc_fix_t   fix_q, fix_d;
  logic         ir_now;
  logic         front_cmd, exec_cmd, exec_take;
  logic [5:0]   new_exc;
  logic [2:0]   top_dec, top_inc;

  // ****************************************
  // Functions
  // ****************************************
  // Class code {C3,C2,C1,C0} with sign into C1
  function automatic logic [3:0] exam_code(input fpusc_cls_t cls, input logic sgn);
    logic [3:0] code;
    code = 4'h0;
    case (cls)
      FPUSC_CLS_UNNORM: code = 4'h0;
      FPUSC_CLS_INVAL0: code = 4'h1;
      FPUSC_CLS_NORMAL: code = 4'h4;
      FPUSC_CLS_INF:    code = 4'h5;
      FPUSC_CLS_ZERO:   code = 4'h8;
      FPUSC_CLS_EMPTY:  code = 4'h9;
      FPUSC_CLS_INVAL1: code = 4'hc;
      default:          code = 4'h9;
    endcase
    return {code[3:2], sgn, code[0]};
  endfunction

  // Pending request: a flag whose mask bit is clear
  function automatic logic pending(input logic [5:0] flg, input logic [15:0] cw);
    return |(flg & ~cw[5:0]);
  endfunction

  // ****************************************
  // Command decode
  // ****************************************
  assign front_cmd = cmd_valid && (cmd_op == FPUSC_CMD_LOAD_CW || cmd_op == FPUSC_CMD_CLR_EXC
                     || cmd_op == FPUSC_CMD_STORE);
  assign exec_cmd  = cmd_valid && (cmd_op == FPUSC_CMD_PUSH || cmd_op == FPUSC_CMD_POP
                     || cmd_op == FPUSC_CMD_COMPARE || cmd_op == FPUSC_CMD_PREM
                     || cmd_op == FPUSC_CMD_EXAMINE || cmd_op == FPUSC_CMD_ARITH);
  // Start never waits on flags or masks
  assign exec_take = exec_cmd && (state_q == FPUSC_ST_IDLE); // RULE_16
  assign top_dec   = top_q - 3'h1;
  assign top_inc   = top_q + 3'h1;

  // ****************************************
  // Execution state, stack top and occupancy
  // ****************************************
  // Run from accepted start to completion pulse
  always_comb begin
    state_d = state_q;
    op_d    = op_q;
    top_d   = top_q;
    occ_d   = occ_q;
    case (state_q)
      FPUSC_ST_IDLE: begin
        if (exec_take) begin
          state_d = FPUSC_ST_RUN; // RULE_22
          op_d    = cmd_op;
          if (cmd_op == FPUSC_CMD_PUSH) begin
            top_d        = top_dec; // RULE_21
            occ_d[top_dec] = 1'b1;
          end
        end
      end
      FPUSC_ST_RUN: begin
        if (exec_done) begin
          state_d = FPUSC_ST_IDLE;
          if (op_q == FPUSC_CMD_POP) begin
            occ_d[top_q] = 1'b0;
            top_d        = top_inc; // RULE_21
          end
        end
      end
      default: begin
        state_d = FPUSC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= FPUSC_ST_IDLE;
      op_q    <= FPUSC_CMD_NOP;
      top_q   <= 3'h0;
      occ_q   <= 8'h00;
    end else begin
      state_q <= state_d;
      op_q    <= op_d;
      top_q   <= top_d;
      occ_q   <= occ_d;
    end
  end

  // ****************************************
  // Exception flags and fix-up
  // ****************************************
  // Collect stack faults at start, datapath faults at completion
  always_comb begin
    new_exc = 6'h00;
    fix_d   = fix_q;
    if (exec_take) begin
      fix_d = FPUSC_FIX_NONE;
      if (cmd_op == FPUSC_CMD_PUSH && occ_q[top_dec]) begin
        new_exc[EXC_INVALID] = 1'b1; // RULE_18
      end
      if (cmd_op == FPUSC_CMD_POP && !occ_q[top_q]) begin
        new_exc[EXC_INVALID] = 1'b1; // RULE_18
      end
    end
    if (state_q == FPUSC_ST_RUN && exec_done) begin
      new_exc = new_exc | exec_exc; // RULE_05 RULE_18
    end
    if (new_exc[EXC_INVALID] && cw_q[EXC_INVALID]) begin
      fix_d = (exec_nan_operand && state_q == FPUSC_ST_RUN) ? FPUSC_FIX_PROP
              : FPUSC_FIX_QNAN; // RULE_17 RULE_19
    end
    // New events win over a clear in the same cycle
    flags_d = flags_q & ~((front_cmd && cmd_op == FPUSC_CMD_CLR_EXC) ? 6'h3f : 6'h00);
    flags_d = flags_d | new_exc; // RULE_17 RULE_23
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_q <= 6'h00;
      fix_q   <= FPUSC_FIX_NONE;
    end else begin
      flags_q <= flags_d;
      fix_q   <= fix_d;
    end
  end

  // ****************************************
  // Condition codes
  // ****************************************
  // Bits held as {C3,C2,C1,C0}
  always_comb begin
    cc_d = cc_q;
    if (state_q == FPUSC_ST_RUN && exec_done) begin
      case (op_q)
        FPUSC_CMD_COMPARE: begin
          case (cmp_result)
            FPUSC_CMP_GT: cc_d = {1'b0, 1'b0, cc_q[1], 1'b0}; // RULE_07
            FPUSC_CMP_LT: cc_d = {1'b0, 1'b0, cc_q[1], 1'b1}; // RULE_07
            FPUSC_CMP_EQ: cc_d = {1'b1, 1'b0, cc_q[1], 1'b0}; // RULE_07
            default:      cc_d = {1'b1, 1'b1, cc_q[1], 1'b1}; // RULE_07
          endcase
        end
        FPUSC_CMD_PREM: begin
          if (rem_complete) begin
            cc_d[2] = 1'b0; // RULE_08
            cc_d[0] = rem_quot[2]; // RULE_08
            if (rem_range == FPUSC_RNG_GE4) begin
              cc_d[3] = rem_quot[1]; // RULE_08
              cc_d[1] = rem_quot[0]; // RULE_08
            end else if (rem_range == FPUSC_RNG_LT4) begin
              cc_d[1] = rem_quot[0]; // RULE_10
            end
          end else begin
            cc_d[2] = 1'b1; // RULE_08
          end
        end
        FPUSC_CMD_EXAMINE: cc_d = exam_code(exam_class, exam_sign); // RULE_09
        default: cc_d = cc_q;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cc_q <= 4'h0;
    end else begin
      cc_q <= cc_d;
    end
  end

  // ****************************************
  // Control word and output pins
  // ****************************************
  // Load from host; fields feed the datapath directly
  always_comb begin
    cw_d = cw_q;
    if (front_cmd && cmd_op == FPUSC_CMD_LOAD_CW) begin
      cw_d = cmd_data & CW_WRITE_MASK; // RULE_20 RULE_11 RULE_12 RULE_13 RULE_14
    end
    ir_now     = pending(flags_d, cw_d); // RULE_04 RULE_23
    int_pin_d  = ir_now && !cw_d[CW_GMASK_BIT]; // RULE_15 RULE_11
    busy_pin_d = (state_d == FPUSC_ST_RUN); // RULE_22 RULE_02
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cw_q       <= CW_RESET;
      int_pin_q  <= 1'b0;
      busy_pin_q <= 1'b0;
    end else begin
      cw_q       <= cw_d;
      int_pin_q  <= int_pin_d;
      busy_pin_q <= busy_pin_d;
    end
  end

  // ****************************************
  // Status word assembly
  // ****************************************
  // Busy covers execution and pending request
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_word_q <= SW_RESET;
    end else begin
      status_word_q <= {busy_pin_d | ir_now, top_d, cc_d[3:0], ir_now, 1'b0, flags_d};
    end
  end // RULE_01 RULE_03 RULE_04 RULE_05

  assign control_word_q = cw_q;
  assign nan_fixup_q    = fix_q;

  // ****************************************
  // Saved pointers
  // ****************************************
  // Captured on every accepted math instruction; operand address only when cmd_has_mem is set
  fpusc_ptr_mem u_ptr_mem (
    .core_clk   (core_clk),
    .reset_n    (reset_n),
    .wr_en      (exec_take), // RULE_06
    .wr_opnd_en (cmd_has_mem),
    .wr_instr   (cmd_instr_addr),
    .wr_opnd    (cmd_opnd_addr),
    .wr_opcode  (cmd_opcode),
    .rd_sel     (ptr_rd_sel),
    .rd_data_q  (ptr_rd_data_q)
  );

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence s_push_start;
    exec_take && cmd_op == FPUSC_CMD_PUSH;
  endsequence

  sequence s_pop_end;
    state_q == FPUSC_ST_RUN && exec_done && op_q == FPUSC_CMD_POP;
  endsequence

  busy_bit_a: assert property (status_word_q[15] == (busy_pin_q || status_word_q[7]))
    else $error("busy bit disagrees with execution or request"); // RULE_01
  front_nobusy_a: assert property (state_q == FPUSC_ST_IDLE && front_cmd && !exec_cmd
    |=> !busy_pin_q) else $error("front instruction set busy"); // RULE_02
  push_top_a: assert property (s_push_start |=> status_word_q[14:12] == $past(top_q) - 3'h1)
    else $error("push did not decrement top"); // RULE_21
  pop_top_a: assert property (s_pop_end |=> status_word_q[14:12] == $past(top_q) + 3'h1)
    else $error("pop did not increment top"); // RULE_21
  ir_bit_a: assert property (status_word_q[7] == |(status_word_q[5:0] & ~cw_q[5:0]))
    else $error("request bit mismatch"); // RULE_04
  int_pin_a: assert property (int_pin_q == (status_word_q[7] && !cw_q[CW_GMASK_BIT]))
    else $error("interrupt pin mismatch"); // RULE_15
  flag_sticky_a: assert property (flags_q[EXC_INVALID] && !(cmd_valid
    && cmd_op == FPUSC_CMD_CLR_EXC) |=> flags_q[EXC_INVALID])
    else $error("flag dropped without clear"); // RULE_23
  cmp_eq_a: assert property (state_q == FPUSC_ST_RUN && exec_done && op_q == FPUSC_CMD_COMPARE
    && cmp_result == FPUSC_CMP_EQ |=> status_word_q[11:8] == {2'b10, $past(cc_q[1]), 1'b0})
    else $error("compare equal code wrong"); // RULE_07
  rem_keep_a: assert property (state_q == FPUSC_ST_RUN && exec_done && op_q == FPUSC_CMD_PREM
    && rem_complete && rem_range == FPUSC_RNG_LT2 |=> cc_q[3] == $past(cc_q[3])
    && cc_q[1] == $past(cc_q[1]) && !cc_q[2]) else $error("remainder kept bits changed"); // RULE_10
  busy_start_a: assert property (exec_take |=> busy_pin_q [*1] ##0 state_q == FPUSC_ST_RUN)
    else $error("busy not raised at start"); // RULE_22
  cw_load_a: assert property (front_cmd && cmd_op == FPUSC_CMD_LOAD_CW
    |=> cw_q == ($past(cmd_data) & CW_WRITE_MASK)) else $error("control load lost"); // RULE_20
  masked_fix_a: assert property (exec_take && cmd_op == FPUSC_CMD_POP && !occ_q[top_q]
    && cw_q[EXC_INVALID] |=> flags_q[EXC_INVALID] && fix_q == FPUSC_FIX_QNAN)
    else $error("masked underflow without fix-up"); // RULE_17

endmodule

/* File: fpusc_exec_model.sv */
// Execution unit stand-in that finishes each started instruction after a set delay
`timescale 1ns/1ns
module fpusc_exec_model (
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic       busy_pin_q,
  input  wire logic [7:0] lat,
  input  wire logic [5:0] exc_val,
  output logic            exec_done,
  output logic [5:0]      exec_exc
);
  logic [7:0] cnt_q;

  // Count the running instruction and pulse done once per start
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q     <= 8'h00;
      exec_done <= 1'b0;
    end else begin
      exec_done <= 1'b0;
      if (busy_pin_q && !exec_done) begin
        cnt_q     <= (cnt_q == lat) ? 8'h00 : cnt_q + 8'h01;
        exec_done <= (cnt_q == lat);
      end
    end
  end

  // Exception lines mean nothing away from done, so show the inverse there
  assign exec_exc = exec_done ? exc_val : ~exc_val;
endmodule

/* File: fpusc_pkg.sv */
// Package: status, control and exception constants for the coprocessor status unit
package fpusc_pkg;

  // ****************************************
  // Status word layout
  // ****************************************
  localparam int SW_BUSY_BIT = 15;
  localparam int SW_TOP_HI   = 14;
  localparam int SW_TOP_LO   = 12;
  localparam int SW_C3_BIT   = 11;
  localparam int SW_C2_BIT   = 10;
  localparam int SW_C1_BIT   = 9;
  localparam int SW_C0_BIT   = 8;
  localparam int SW_IR_BIT   = 7;
  localparam logic [15:0] SW_RESET = 16'h0000;

  // ****************************************
  // Control word layout
  // ****************************************
  localparam int CW_GMASK_BIT = 7;
  localparam int CW_PREC_LO   = 8;
  localparam int CW_RND_LO    = 10;
  localparam int CW_INF_BIT   = 12;
  localparam logic [15:0] CW_RESET = 16'h03bf;
  localparam logic [15:0] CW_WRITE_MASK = 16'h1fbf;

  // ****************************************
  // Exception flag positions
  // ****************************************
  localparam int EXC_INVALID   = 0;
  localparam int EXC_DENORMAL  = 1;
  localparam int EXC_ZERO_DIV  = 2;
  localparam int EXC_OVERFLOW  = 3;
  localparam int EXC_UNDERFLOW = 4;
  localparam int EXC_PRECISION = 5;

  // ****************************************
  // Commands from the instruction stream
  // ****************************************
  typedef enum logic [3:0] {
    FPUSC_CMD_NOP     = 4'h0,
    FPUSC_CMD_LOAD_CW = 4'h1,
    FPUSC_CMD_CLR_EXC = 4'h2,
    FPUSC_CMD_STORE   = 4'h3,
    FPUSC_CMD_PUSH    = 4'h4,
    FPUSC_CMD_POP     = 4'h5,
    FPUSC_CMD_COMPARE = 4'h6,
    FPUSC_CMD_PREM    = 4'h7,
    FPUSC_CMD_EXAMINE = 4'h8,
    FPUSC_CMD_ARITH   = 4'h9
  } fpusc_cmd_t;

  // Compare outcome from the datapath
  typedef enum logic [1:0] {
    FPUSC_CMP_GT  = 2'h0,
    FPUSC_CMP_LT  = 2'h1,
    FPUSC_CMP_EQ  = 2'h2,
    FPUSC_CMP_UNO = 2'h3
  } fpusc_cmp_t;

  // Remainder dividend range
  typedef enum logic [1:0] {
    FPUSC_RNG_LT2 = 2'h0,
    FPUSC_RNG_LT4 = 2'h1,
    FPUSC_RNG_GE4 = 2'h2
  } fpusc_rng_t;

  // Operand class for examine
  typedef enum logic [2:0] {
    FPUSC_CLS_UNNORM = 3'h0,
    FPUSC_CLS_INVAL0 = 3'h1,
    FPUSC_CLS_NORMAL = 3'h2,
    FPUSC_CLS_INF    = 3'h3,
    FPUSC_CLS_ZERO   = 3'h4,
    FPUSC_CLS_EMPTY  = 3'h5,
    FPUSC_CLS_INVAL1 = 3'h6
  } fpusc_cls_t;

  // Masked invalid fix-up applied to the result
  typedef enum logic [1:0] {
    FPUSC_FIX_NONE  = 2'h0,
    FPUSC_FIX_QNAN  = 2'h1,
    FPUSC_FIX_PROP  = 2'h2
  } fpusc_fix_t;

  // Execution state
  typedef enum logic {
    FPUSC_ST_IDLE = 1'b0,
    FPUSC_ST_RUN  = 1'b1
  } fpusc_state_t;

  // Saved pointer entries
  localparam logic [1:0] PTR_INSTR   = 2'h0;
  localparam logic [1:0] PTR_OPERAND = 2'h1;
  localparam logic [1:0] PTR_OPCODE  = 2'h2;
  localparam int PTR_W = 20;

endpackage

/* File: fpusc_ptr_mem.sv */
// Saved instruction address, operand address and opcode store
`timescale 1ns/1ns
module fpusc_ptr_mem (
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  input  wire logic              wr_en,
  input  wire logic              wr_opnd_en,
  input  wire logic [19:0]       wr_instr,
  input  wire logic [19:0]       wr_opnd,
  input  wire logic [10:0]       wr_opcode,
  input  wire logic [1:0]        rd_sel,
  output logic      [19:0]       rd_data_q
);
  import fpusc_pkg::*;

  logic [19:0] mem_q [0:2];
  logic [19:0] mem_d [0:2];
  logic [19:0] rd_data_d;

  // Next contents and read word
  always_comb begin
    mem_d[0] = mem_q[0];
    mem_d[1] = mem_q[1];
    mem_d[2] = mem_q[2];
    if (wr_en) begin
      mem_d[PTR_INSTR]  = wr_instr;
      mem_d[PTR_OPCODE] = {9'h000, wr_opcode};
      if (wr_opnd_en) begin
        mem_d[PTR_OPERAND] = wr_opnd;
      end
    end
    rd_data_d = (rd_sel == 2'h3) ? 20'h00000 : mem_q[rd_sel];
  end

  // Storage and registered read port
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_q[0]  <= 20'h00000;
      mem_q[1]  <= 20'h00000;
      mem_q[2]  <= 20'h00000;
      rd_data_q <= 20'h00000;
    end else begin
      mem_q[0]  <= mem_d[0];
      mem_q[1]  <= mem_d[1];
      mem_q[2]  <= mem_d[2];
      rd_data_q <= rd_data_d;
    end
  end

endmodule

/* File: tb.sv */
// Self-checking bench for the coprocessor status and control unit
`timescale 1ns/1ns
module tb;
  import fpusc_pkg::*;
  typedef struct { int k; logic [19:0] e; } fpusc_note_t;

  logic        core_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        cmd_valid = 1'b0;
  fpusc_cmd_t  cmd_op = FPUSC_CMD_NOP;
  logic [15:0] cmd_data = 16'h0000;
  logic        cmd_has_mem = 1'b0;
  logic [19:0] cmd_instr_addr = 20'h00000;
  logic [19:0] cmd_opnd_addr = 20'h00000;
  logic [10:0] cmd_opcode = 11'h000;
  logic        exec_done;
  logic [5:0]  exec_exc;
  logic        exec_nan_operand = 1'b0;
  fpusc_cmp_t  cmp_result = FPUSC_CMP_GT;
  logic        rem_complete = 1'b0;
  fpusc_rng_t  rem_range = FPUSC_RNG_LT2;
  logic [2:0]  rem_quot = 3'h0;
  fpusc_cls_t  exam_class = FPUSC_CLS_UNNORM;
  logic        exam_sign = 1'b0;
  logic [1:0]  ptr_rd_sel = 2'h0;
  logic [15:0] status_word_q;
  logic [15:0] control_word_q;
  logic        busy_pin_q;
  logic        int_pin_q;
  fpusc_fix_t  nan_fixup_q;
  logic [19:0] ptr_rd_data_q;
  logic [7:0]  lat = 8'h00;
  logic [5:0]  exc_val = 6'h00;
  int          miscompares = 0;
  int          n_compared = 0;
  logic [2:0]  top = 3'h0;
  logic [3:0]  cc = 4'h0;
  logic [5:0]  flags = 6'h00;
  logic [15:0] cw = CW_RESET;
  logic [19:0] pa, po;
  logic [10:0] pc;
  logic [15:0] d;
  logic [5:0]  e;
  logic [3:0]  n4;
  logic [2:0]  qv;
  logic        sg, nv;
  fpusc_note_t q[$];
  fpusc_note_t n;
  event        ev;
  logic [3:0]  cls_cc [7] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hc};
  logic [3:0]  cmp_cc [4] = '{4'h0, 4'h1, 4'h8, 4'hd};

  fpusc_core u_dut (.core_clk(core_clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_has_mem(cmd_has_mem),
    .cmd_instr_addr(cmd_instr_addr), .cmd_opnd_addr(cmd_opnd_addr), .cmd_opcode(cmd_opcode),
    .exec_done(exec_done), .exec_exc(exec_exc), .exec_nan_operand(exec_nan_operand),
    .cmp_result(cmp_result), .rem_complete(rem_complete), .rem_range(rem_range),
    .rem_quot(rem_quot), .exam_class(exam_class), .exam_sign(exam_sign),
    .ptr_rd_sel(ptr_rd_sel), .status_word_q(status_word_q), .control_word_q(control_word_q),
    .busy_pin_q(busy_pin_q), .int_pin_q(int_pin_q), .nan_fixup_q(nan_fixup_q),
    .ptr_rd_data_q(ptr_rd_data_q));

  fpusc_exec_model u_model (.core_clk(core_clk), .reset_n(reset_n), .busy_pin_q(busy_pin_q),
    .lat(lat), .exc_val(exc_val), .exec_done(exec_done), .exec_exc(exec_exc));

  // Clock at 4 ns
  always #2 core_clk = ~core_clk;

  // Expected status word and interrupt pin from the tracked state
  function logic [15:0] sw(input logic run);
    logic req;
    req = |(flags & ~cw[5:0]);
    sw = {run | req, top, cc, req, 1'b0, flags};
  endfunction
  function logic intr();
    intr = (|(flags & ~cw[5:0])) & ~cw[CW_GMASK_BIT];
  endfunction

  task wrap_up;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task cmp_word(input string nm, input logic [15:0] ex, input logic [15:0] g);
    n_compared++;
    if (g !== ex) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, g);
    end
  endtask
  task cmp_ptr(input string nm, input logic [19:0] ex, input logic [19:0] g);
    n_compared++;
    if (g !== ex) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, g);
    end
  endtask

  // Note an expected value; the watcher compares it against the outputs
  task note(input int k, input logic [15:0] v);
    q.push_back('{k, {4'h0, v}});
    ->ev;
  endtask

  // Watcher drains every queued note, oldest first, each time a note is posted
  always @(ev) begin
    while (q.size() > 0) begin
      n = q.pop_front();
      case (n.k)
        0: cmp_word("status", n.e[15:0], status_word_q);
        1: cmp_word("control", n.e[15:0], control_word_q);
        2: cmp_word("busy_int", n.e[15:0], {14'h0000, busy_pin_q, int_pin_q});
        3: cmp_word("fixup", n.e[15:0], {14'h0000, nan_fixup_q});
        default: cmp_ptr("pointer", n.e, ptr_rd_data_q);
      endcase
    end
  end

  task settle;
    @(posedge core_clk);
    #1;
  endtask

  task cmd(input fpusc_cmd_t op, input logic [15:0] v);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_data <= v;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
  endtask

  // One math instruction: start, mid-run look, bounded wait for completion
  task math(input fpusc_cmd_t op, input logic [5:0] ex, input int l, input logic sf,
            input logic [3:0] ncc);
    int i;
    @(posedge core_clk);
    exc_val <= ex;
    lat <= 8'(l);
    cmd(op, 16'h0000);
    if (op == FPUSC_CMD_PUSH) top = top - 3'h1;
    if (sf) flags[EXC_INVALID] = 1'b1;
    settle;
    note(0, sw(1'b1));
    note(2, {14'h0000, 1'b1, intr()});
    i = 0;
    while (busy_pin_q !== 1'b0 && i < 200) begin
      settle;
      i++;
    end
    if (i == 200) begin
      miscompares++;
      wrap_up;
    end
    if (op == FPUSC_CMD_POP) top = top + 3'h1;
    flags = flags | ex;
    cc = ncc;
    note(0, sw(1'b0));
    note(2, {14'h0000, 1'b0, intr()});
  endtask

  initial begin
    void'($urandom(47));
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    settle;
    note(0, sw(1'b0));
    note(1, cw);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      d = 16'($urandom);
      d[9:8] = 2'(i);
      d[11:10] = 2'(3 - i);
      d[CW_INF_BIT] = i[0];
      cmd(FPUSC_CMD_LOAD_CW, d);
      cw = d & CW_WRITE_MASK;
      settle;
      note(1, cw);
      note(2, {14'h0000, 1'b0, intr()});
    end
    cmd(FPUSC_CMD_LOAD_CW, CW_RESET);
    cw = CW_RESET;
    $display("test control done");
    pa = 20'($urandom);
    po = 20'($urandom);
    pc = 11'($urandom);
    @(posedge core_clk);
    cmd_instr_addr <= pa;
    cmd_opnd_addr <= po;
    cmd_opcode <= pc;
    cmd_has_mem <= 1'b1;
    math(FPUSC_CMD_PUSH, 6'h00, 20, 1'b0, cc);
    for (int s = 0; s < 4; s++) begin
      @(posedge core_clk);
      ptr_rd_sel <= 2'(s);
      settle;
      settle;
      q.push_back('{4, s == 0 ? pa : s == 1 ? po : s == 2 ? {9'h000, pc} : 20'h00000});
      ->ev;
    end
    $display("test push and pointers done");
    for (int c = 0; c < 7; c++) begin
      sg = 1'($urandom);
      @(posedge core_clk);
      exam_class <= fpusc_cls_t'(c);
      exam_sign <= sg;
      math(FPUSC_CMD_EXAMINE, 6'h00, c, 1'b0, cls_cc[c] | {2'b00, sg, 1'b0});
    end
    for (int r = 0; r < 4; r++) begin
      @(posedge core_clk);
      cmp_result <= fpusc_cmp_t'(r);
      math(FPUSC_CMD_COMPARE, 6'h00, 3, 1'b0, cmp_cc[r] | {2'b00, cc[1], 1'b0});
    end
    for (int k = 0; k < 4; k++) begin
      qv = 3'($urandom);
      n4 = cc;
      if (k == 3) n4[2] = 1'b1;
      else begin
        n4[2] = 1'b0;
        n4[0] = qv[2];
        if (k != 0) n4[1] = qv[0];
        if (k == 2) n4[3] = qv[1];
      end
      @(posedge core_clk);
      rem_complete <= (k != 3);
      rem_range <= fpusc_rng_t'(k == 3 ? 2 : k);
      rem_quot <= qv;
      math(FPUSC_CMD_PREM, 6'h00, 2, 1'b0, n4);
    end
    $display("test condition codes done");
    e = 6'($urandom) | 6'h01;
    nv = 1'($urandom);
    @(posedge core_clk);
    exec_nan_operand <= nv;
    math(FPUSC_CMD_ARITH, e, 5, 1'b0, cc);
    note(3, nv ? 16'h0002 : 16'h0001);
    cmd(FPUSC_CMD_LOAD_CW, 16'h0300);
    cw = 16'h0300;
    settle;
    note(0, sw(1'b0));
    note(2, {14'h0000, 1'b0, intr()});
    cmd(FPUSC_CMD_LOAD_CW, 16'h0380);
    cw = 16'h0380;
    settle;
    note(2, {14'h0000, 1'b0, intr()});
    math(FPUSC_CMD_ARITH, 6'h00, 4, 1'b0, cc);
    cmd(FPUSC_CMD_LOAD_CW, 16'h0300);
    cw = 16'h0300;
    math(FPUSC_CMD_ARITH, 6'h04, 1, 1'b0, cc);
    cmd(FPUSC_CMD_CLR_EXC, 16'h0000);
    flags = 6'h00;
    settle;
    note(0, sw(1'b0));
    note(2, {14'h0000, 1'b0, intr()});
    cmd(FPUSC_CMD_STORE, 16'h0000);
    settle;
    note(0, sw(1'b0));
    cmd(FPUSC_CMD_LOAD_CW, CW_RESET);
    cw = CW_RESET;
    $display("test exceptions done");
    for (int j = 0; j < 8; j++) math(FPUSC_CMD_PUSH, 6'h00, 0, j == 7, cc);
    note(3, 16'h0001);
    $display("test stack overflow done");
    cmd(FPUSC_CMD_CLR_EXC, 16'h0000);
    flags = 6'h00;
    for (int j = 0; j < 9; j++) math(FPUSC_CMD_POP, 6'h00, 0, j == 8, cc);
    note(3, 16'h0001);
    $display("test stack underflow done");
    settle;
    wrap_up;
  end
endmodule
